// ==== rtl/two_wire_pkg.sv ====
// Shared constants for the two-wire status and recovery unit.
package two_wire_pkg;
  // Register map on the AXI4-Lite slave.
  localparam int         ADDR_W      = 5;
  localparam logic [4:0] CTRL_OFF    = 5'h00;
  localparam logic [4:0] STAT_OFF    = 5'h04;
  localparam logic [4:0] OWN_OFF     = 5'h08;
  localparam logic [4:0] DATA_OFF    = 5'h0C;
  localparam int         START_BIT   = 0;
  localparam int         STOP_BIT    = 1;
  localparam int         INT_BIT     = 2;
  localparam int         ACK_BIT     = 3;
  localparam logic [7:0] OWN_RST     = 8'h00;
  localparam logic [7:0] DATA_RST    = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Status codes.
  localparam logic [7:0] ST_NONE      = 8'hF8;
  localparam logic [7:0] ST_BUS_ERR   = 8'h00;
  localparam logic [7:0] ST_START     = 8'h08;
  localparam logic [7:0] ST_RSTART    = 8'h10;
  localparam logic [7:0] ST_MADDR_ACK = 8'h18;
  localparam logic [7:0] ST_MADDR_NAK = 8'h20;
  localparam logic [7:0] ST_LOST      = 8'h38;
  localparam logic [7:0] ST_SLV_W     = 8'h60;
  localparam logic [7:0] ST_LOST_W    = 8'h68;
  localparam logic [7:0] ST_GCALL     = 8'h70;
  localparam logic [7:0] ST_LOST_GC   = 8'h78;
  localparam logic [7:0] ST_SLV_R     = 8'hA8;
  localparam logic [7:0] ST_LOST_R    = 8'hB0;
  localparam logic [7:0] ST_TX_ACK    = 8'hB8;
  localparam logic [7:0] ST_TX_NAK    = 8'hC0;
  localparam logic [7:0] ST_TX_LAST   = 8'hC8;
  // Line timing.
  localparam int         CLK_NS         = 4;
  localparam int         HALF_BIT_NS    = 5000;
  localparam int         HALF_BIT_CYC   = (HALF_BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int         TICK_W         = 11;
  localparam logic [2:0] RECOVERY_EDGES = 3'h4;
endpackage

// ==== rtl/line_if.sv ====
// Conditioned bus line levels and events passed from the monitor to the controller.
`timescale 1ns/10ps
interface line_if;
  logic sclLevel;
  logic sdaLevel;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  modport mon (output sclLevel, sdaLevel, sclRise, sclFall, startSeen, stopSeen);
  modport ctl (input sclLevel, sdaLevel, sclRise, sclFall, startSeen, stopSeen);
endinterface

// ==== rtl/line_monitor.sv ====
// Synchronises the bus lines and finds the clock edges, START and STOP.
`timescale 1ns/10ps
module line_monitor (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Bus pins
  input  wire logic sclIn,
  input  wire logic sdaIn,
  // Conditioned lines
  line_if.mon       lines
);
  typedef struct packed {
    logic sclMeta;
    logic sclSync;
    logic sclPrev;
    logic sdaMeta;
    logic sdaSync;
    logic sdaPrev;
  } mon_t;

  mon_t mon_q;
  mon_t mon_d;

  always_comb begin
    mon_d = mon_q;
    mon_d.sclMeta = sclIn;
    mon_d.sclSync = mon_q.sclMeta;
    mon_d.sclPrev = mon_q.sclSync;
    mon_d.sdaMeta = sdaIn;
    mon_d.sdaSync = mon_q.sdaMeta;
    mon_d.sdaPrev = mon_q.sdaSync;
  end

  // Lines reset high so an idle bus shows no false event.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mon_q <= '1;
    end else begin
      mon_q <= mon_d;
    end
  end

  assign lines.sclLevel  = mon_q.sclSync;
  assign lines.sdaLevel  = mon_q.sdaSync;
  assign lines.sclRise   = mon_q.sclSync & ~mon_q.sclPrev;
  assign lines.sclFall   = ~mon_q.sclSync & mon_q.sclPrev;
  assign lines.startSeen = mon_q.sclSync & mon_q.sclPrev & mon_q.sdaPrev & ~mon_q.sdaSync;
  assign lines.stopSeen  = mon_q.sclSync & mon_q.sclPrev & ~mon_q.sdaPrev & mon_q.sdaSync;
endmodule

// ==== rtl/half_bit_timer.sv ====
// Free running strobe that paces the clock edges the unit drives as master.
`timescale 1ns/10ps
module half_bit_timer import two_wire_pkg::*; (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Strobe, one cycle every half bit
  output logic      tick
);
  typedef struct packed {
    logic [TICK_W-1:0] count;
    logic              tick;
  } timer_t;

  timer_t timer_q;
  timer_t timer_d;

  always_comb begin
    timer_d = timer_q;
    timer_d.tick = 1'b0;
    if (timer_q.count == TICK_W'(HALF_BIT_CYC - 1)) begin
      timer_d.count = '0;
      timer_d.tick = 1'b1;
    end else begin
      timer_d.count = timer_q.count + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer_q <= '0;
    end else begin
      timer_q <= timer_d;
    end
  end

  assign tick = timer_q.tick;
endmodule

// ==== rtl/two_wire_unit.sv ====
// Two-wire unit: status code, bus error, slave transmit and master recovery.
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module two_wire_unit import two_wire_pkg::*; (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Bus pins, open drain
  input  wire logic              sclIn,
  output logic                   sclOut,
  output logic                   sclOe,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOe
);
  typedef enum logic [3:0] {
    IDLE, ADDR, SACK, STX_WAIT, STX, SDONE, SRX, START,
    START2, CLK, MHOLD, MTX, STOP, RSTART, ERR
  } state_t;

  typedef struct packed {
    state_t     state;
    logic [7:0] code;
    logic       intFlag;
    logic       startReq;
    logic       stopReq;
    logic       ackEnable;
    logic [7:0] ownAddr;
    logic [7:0] txData;
    logic [7:0] shift;
    logic [7:0] rxByte;
    logic [3:0] bitCnt;
    logic       phase;
    logic       lostArb;
    logic       lastByte;
    logic       isRead;
    logic       repStart;
    logic       busy;
    logic [2:0] edges;
    logic       sclDrive;
    logic       sdaDrive;
    logic       pinLow;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } unit_t;

  unit_t regs_q;
  unit_t regs_d;
  logic  tick;
  logic  busErr;

  line_if lines ();

  line_monitor monitor (
    .core_clk (core_clk),
    .rst      (rst),
    .sclIn    (sclIn),
    .sdaIn    (sdaIn),
    .lines    (lines)
  );

  half_bit_timer timer (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Decoders.

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    mapped = (addr == CTRL_OFF) || (addr == STAT_OFF) ||
             (addr == OWN_OFF) || (addr == DATA_OFF);
  endfunction

  function automatic logic addrMatch(input logic [7:0] rx, input logic [7:0] own);
    addrMatch = (rx[7:1] == own[7:1]) || (rx[7:1] == 7'h00 && own[0]);
  endfunction

  function automatic logic [7:0] slaveCode(input logic rd, input logic gc, input logic lost);
    if (rd) begin
      slaveCode = lost ? ST_LOST_R : ST_SLV_R;
    end else if (gc) begin
      slaveCode = lost ? ST_LOST_GC : ST_GCALL;
    end else begin
      slaveCode = lost ? ST_LOST_W : ST_SLV_W;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    regs_d = regs_q;
    busErr = 1'b0;
    regs_d.pinLow = 1'b0;

    // Register bus: write ready for one cycle once address and data are both offered, read ready once the address is.
    regs_d.awready = 1'b0;
    regs_d.wready = 1'b0;
    regs_d.arready = 1'b0;
    if (awvalid && wvalid && !regs_q.awready && !regs_q.bvalid) begin
      regs_d.awready = 1'b1;
      regs_d.wready = 1'b1;
    end
    if (regs_q.bvalid && bready) begin
      regs_d.bvalid = 1'b0;
    end
    if (regs_q.awready) begin
      regs_d.bvalid = 1'b1;
      regs_d.bresp = mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (wstrb[0] && awaddr == CTRL_OFF) begin
        regs_d.startReq = wdata[START_BIT];
        regs_d.stopReq = wdata[STOP_BIT];
        regs_d.ackEnable = wdata[ACK_BIT];
        if (!wdata[INT_BIT]) begin
          regs_d.intFlag = 1'b0;
        end
      end
      if (wstrb[0] && awaddr == OWN_OFF) begin
        regs_d.ownAddr = wdata[7:0];
      end
      if (wstrb[0] && awaddr == DATA_OFF) begin
        regs_d.txData = wdata[7:0];
      end
    end
    if (arvalid && !regs_q.arready && !regs_q.rvalid) begin
      regs_d.arready = 1'b1;
    end
    if (regs_q.rvalid && rready) begin
      regs_d.rvalid = 1'b0;
    end
    if (regs_q.arready) begin
      regs_d.rvalid = 1'b1;
      regs_d.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      regs_d.rdata = '0;
      unique case (araddr)
        CTRL_OFF: regs_d.rdata[3:0] = {regs_q.ackEnable, regs_q.intFlag,
                                        regs_q.stopReq, regs_q.startReq};
        STAT_OFF: regs_d.rdata[7:0] = regs_q.intFlag ? regs_q.code : ST_NONE;
        OWN_OFF:  regs_d.rdata[7:0] = regs_q.ownAddr;
        DATA_OFF: regs_d.rdata[7:0] = regs_q.rxByte;
        default:  regs_d.rdata = '0;
      endcase
    end

    // Bus occupancy as seen from the lines.
    if (lines.startSeen) begin
      regs_d.busy = 1'b1;
    end else if (lines.stopSeen) begin
      regs_d.busy = 1'b0;
    end

    unique case (regs_q.state)
      IDLE: begin
        regs_d.sclDrive = 1'b0;
        regs_d.sdaDrive = 1'b0;
        regs_d.lostArb = 1'b0;
        if (regs_q.stopReq) begin
          regs_d.stopReq = 1'b0;
          if (regs_q.startReq) begin
            regs_d.busy = 1'b0;
          end
        end else if (lines.startSeen) begin
          regs_d.state = ADDR;
          regs_d.bitCnt = '0;
        end else if (regs_q.startReq && !regs_q.busy && !regs_q.intFlag) begin
          regs_d.state = START;
          regs_d.repStart = 1'b0;
        end
      end
      ADDR: begin
        if (lines.stopSeen || (lines.startSeen && regs_q.bitCnt != 4'h0)) begin
          busErr = regs_q.lostArb;
          regs_d.state = lines.stopSeen ? IDLE : ADDR;
          regs_d.bitCnt = '0;
        end else if (lines.sclRise && regs_q.bitCnt < 4'h8) begin
          regs_d.rxByte = {regs_q.rxByte[6:0], lines.sdaLevel};
          regs_d.bitCnt = regs_q.bitCnt + 4'h1;
        end else if (lines.sclFall && regs_q.bitCnt == 4'h8) begin
          if (regs_q.ackEnable && addrMatch(regs_q.rxByte, regs_q.ownAddr)) begin
            regs_d.sdaDrive = 1'b1;
            regs_d.isRead = regs_q.rxByte[0];
            regs_d.state = SACK;
          end else begin
            regs_d.state = IDLE;
            if (regs_q.lostArb) begin
              regs_d.code = ST_LOST;
              regs_d.intFlag = 1'b1;
            end
          end
        end
      end
      SACK: begin
        if (lines.startSeen || lines.stopSeen) begin
          busErr = 1'b1;
        end else if (lines.sclFall) begin
          regs_d.code = slaveCode(regs_q.isRead, regs_q.rxByte[7:1] == 7'h00,
                                  regs_q.lostArb);
          regs_d.intFlag = 1'b1;
          regs_d.sclDrive = 1'b1;
          regs_d.sdaDrive = 1'b0;
          regs_d.lostArb = 1'b0;
          regs_d.state = regs_q.isRead ? STX_WAIT : SRX;
        end
      end
      STX_WAIT: begin
        if (!regs_q.intFlag) begin
          regs_d.shift = regs_q.txData;
          regs_d.lastByte = !regs_q.ackEnable;
          regs_d.bitCnt = '0;
          regs_d.sdaDrive = !regs_q.txData[7];
          regs_d.sclDrive = 1'b0;
          regs_d.state = STX;
        end
      end
      STX: begin
        if (lines.startSeen || lines.stopSeen) begin
          busErr = 1'b1;
        end else if (lines.sclRise && regs_q.bitCnt == 4'h8) begin
          regs_d.phase = !lines.sdaLevel;
        end else if (lines.sclFall && regs_q.bitCnt == 4'h8) begin
          regs_d.intFlag = 1'b1;
          regs_d.sclDrive = 1'b1;
          if (!regs_q.phase) begin
            regs_d.code = ST_TX_NAK;
            regs_d.state = SDONE;
          end else if (regs_q.lastByte) begin
            regs_d.code = ST_TX_LAST;
            regs_d.state = SDONE;
          end else begin
            regs_d.code = ST_TX_ACK;
            regs_d.state = STX_WAIT;
          end
        end else if (lines.sclFall) begin
          regs_d.bitCnt = regs_q.bitCnt + 4'h1;
          regs_d.shift = {regs_q.shift[6:0], 1'b0};
          regs_d.sdaDrive = (regs_q.bitCnt < 4'h7) && !regs_q.shift[6];
        end
      end
      SDONE: begin
        if (!regs_q.intFlag) begin
          regs_d.sclDrive = 1'b0;
          regs_d.state = IDLE;
        end
      end
      SRX: begin
        if (!regs_q.intFlag) begin
          regs_d.sclDrive = 1'b0;
        end
        if (lines.stopSeen || lines.startSeen) begin
          regs_d.sclDrive = 1'b0;
          regs_d.bitCnt = '0;
          regs_d.state = lines.startSeen ? ADDR : IDLE;
        end
      end
      START: begin
        regs_d.sclDrive = 1'b0;
        if (tick && !lines.sdaLevel) begin
          regs_d.state = CLK;
          regs_d.edges = '0;
        end else if (tick && lines.sclLevel) begin
          regs_d.sdaDrive = 1'b1;
          regs_d.state = START2;
        end
      end
      START2: begin
        if (tick) begin
          regs_d.sclDrive = 1'b1;
          regs_d.code = regs_q.repStart ? ST_RSTART : ST_START;
          regs_d.intFlag = 1'b1;
          regs_d.state = MHOLD;
        end
      end
      CLK: begin
        if (tick) begin
          regs_d.edges = regs_q.edges + 3'h1;
          regs_d.sclDrive = !regs_q.sclDrive;
          if (regs_q.edges == RECOVERY_EDGES - 3'h1) begin
            regs_d.sclDrive = 1'b0;
            regs_d.repStart = 1'b0;
            regs_d.state = START;
          end
        end
      end
      MHOLD: begin
        regs_d.bitCnt = '0;
        regs_d.phase = 1'b0;
        if (!regs_q.intFlag) begin
          if (regs_q.stopReq) begin
            regs_d.state = STOP;
          end else if (regs_q.startReq) begin
            regs_d.state = RSTART;
          end else begin
            regs_d.shift = regs_q.txData;
            regs_d.lostArb = 1'b0;
            regs_d.state = MTX;
          end
        end
      end
      MTX: begin
        if (lines.startSeen || lines.stopSeen) begin
          busErr = 1'b1;
        end else if (tick && !regs_q.phase) begin
          regs_d.sdaDrive = (regs_q.bitCnt < 4'h8) && !regs_q.shift[7];
          regs_d.sclDrive = 1'b0;
          regs_d.phase = 1'b1;
        end else if (tick && lines.sclLevel) begin
          regs_d.rxByte = {regs_q.rxByte[6:0], lines.sdaLevel};
          regs_d.bitCnt = regs_q.bitCnt + 4'h1;
          regs_d.shift = {regs_q.shift[6:0], 1'b0};
          regs_d.sclDrive = 1'b1;
          regs_d.phase = 1'b0;
          if (regs_q.bitCnt < 4'h8 && !regs_q.sdaDrive && !lines.sdaLevel) begin
            regs_d.lostArb = 1'b1;
            regs_d.sclDrive = 1'b0;
            regs_d.state = ADDR;
          end else if (regs_q.bitCnt == 4'h8) begin
            regs_d.code = lines.sdaLevel ? ST_MADDR_NAK : ST_MADDR_ACK;
            regs_d.intFlag = 1'b1;
            regs_d.state = MHOLD;
          end
        end
      end
      STOP: begin
        if (tick && regs_q.bitCnt == 4'h0) begin
          regs_d.sdaDrive = 1'b1;
          regs_d.bitCnt = 4'h1;
        end else if (tick && regs_q.bitCnt == 4'h1) begin
          regs_d.sclDrive = 1'b0;
          regs_d.bitCnt = 4'h2;
        end else if (tick && lines.sclLevel) begin
          regs_d.sdaDrive = 1'b0;
          regs_d.stopReq = 1'b0;
          regs_d.state = IDLE;
        end
      end
      RSTART: begin
        if (lines.startSeen && regs_q.bitCnt != 4'h0) begin
          regs_d.sclDrive = 1'b0;
          regs_d.sdaDrive = 1'b0;
          regs_d.state = IDLE;
        end else if (tick && regs_q.bitCnt == 4'h0) begin
          regs_d.sdaDrive = 1'b0;
          regs_d.bitCnt = 4'h1;
        end else if (tick && regs_q.bitCnt == 4'h1) begin
          regs_d.sclDrive = 1'b0;
          regs_d.bitCnt = 4'h2;
        end else if (tick && lines.sclLevel) begin
          if (!lines.sdaLevel) begin
            regs_d.edges = '0;
            regs_d.state = CLK;
          end else begin
            regs_d.sdaDrive = 1'b1;
            regs_d.repStart = 1'b1;
            regs_d.state = START2;
          end
        end
      end
      ERR: begin
        regs_d.sclDrive = 1'b0;
        regs_d.sdaDrive = 1'b0;
        if (!regs_q.intFlag && regs_q.stopReq) begin
          regs_d.stopReq = 1'b0;
          regs_d.state = IDLE;
        end
      end
      default: begin
        busErr = 1'b1;
      end
    endcase

    // Bus error: release both lines at once, no STOP, flag 00H.
    if (busErr) begin
      regs_d.code = ST_BUS_ERR;
      regs_d.intFlag = 1'b1;
      regs_d.sclDrive = 1'b0;
      regs_d.sdaDrive = 1'b0;
      regs_d.lostArb = 1'b0;
      regs_d.state = ERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge core_clk) begin
    if (rst) begin
      regs_q <= '0;
      regs_q.state <= IDLE;
      regs_q.code <= ST_NONE;
      regs_q.ownAddr <= OWN_RST;
      regs_q.txData <= DATA_RST;
    end else begin
      regs_q <= regs_d;
    end
  end

  assign awready = regs_q.awready;
  assign wready  = regs_q.wready;
  assign bvalid  = regs_q.bvalid;
  assign bresp   = regs_q.bresp;
  assign arready = regs_q.arready;
  assign rvalid  = regs_q.rvalid;
  assign rdata   = regs_q.rdata;
  assign rresp   = regs_q.rresp;
  assign sclOut  = regs_q.pinLow;
  assign sclOe   = regs_q.sclDrive;
  assign sdaOut  = regs_q.pinLow;
  assign sdaOe   = regs_q.sdaDrive;
endmodule

// ==== test/two_wire_unit_monitor.sv ====
// Handshake and line checks for the two-wire unit.
`timescale 1ns/10ps
module two_wire_unit_monitor import two_wire_pkg::*; (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Register bus
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  // Bus pins
  input wire logic        sclOut,
  input wire logic        sdaOut,
  input wire logic        sclOe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_drain; !sclOut && !sdaOut; endproperty
  a_drain: assert property (p_drain) else $error("line driven high");
  property p_wPair; awready |-> wready; endproperty
  a_wPair: assert property (p_wPair) else $error("write ready split");
  property p_bLat; awready |=> bvalid; endproperty
  a_bLat: assert property (p_bLat) else $error("write answer late");
  property p_bOnce; bvalid && bready |=> !bvalid; endproperty
  a_bOnce: assert property (p_bOnce) else $error("write answer repeated");
  property p_rLat; arready |=> rvalid; endproperty
  a_rLat: assert property (p_rLat) else $error("read answer late");
  property p_rOnce; rvalid && rready |=> !rvalid; endproperty
  a_rOnce: assert property (p_rOnce) else $error("read answer repeated");
  property p_rTop; rvalid |-> rdata[31:8] == 24'h0; endproperty
  a_rTop: assert property (p_rTop) else $error("upper read bits set");
  property p_rErr; rvalid && rresp != RESP_OKAY |-> rdata == 32'h0; endproperty
  a_rErr: assert property (p_rErr) else $error("error read with data");
  property p_sclHold; $rose(sclOe) |=> sclOe [*8]; endproperty
  a_sclHold: assert property (p_sclHold) else $error("clock pulse too short");
endmodule
bind two_wire_unit two_wire_unit_monitor u_mon (
  .core_clk (core_clk),
  .rst      (rst),
  .awready  (awready),
  .wready   (wready),
  .bvalid   (bvalid),
  .bready   (bready),
  .arready  (arready),
  .rvalid   (rvalid),
  .rready   (rready),
  .rdata    (rdata),
  .rresp    (rresp),
  .sclOut   (sclOut),
  .sdaOut   (sdaOut),
  .sclOe    (sclOe)
);

// ==== test/bus_peer.sv ====
// Far side of the two-wire bus: a master working open-drain pulls.
`timescale 1ns/10ps
module bus_peer (
  // Clock
  input  wire logic core_clk,
  // Bus levels
  input  wire logic sclLine,
  input  wire logic sdaLine,
  // Pulls, high pulls the line low
  output logic      sclPull,
  output logic      sdaPull
);
  logic stalled = 1'b0;
  initial begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
  end
  task automatic hw();
    repeat (20) @(posedge core_clk);
  endtask
  // One bit; waits while another party stretches the clock low.
  task automatic bit1(input logic b, output logic s);
    int n;
    sdaPull <= !b;
    hw();
    sclPull <= 1'b0;
    n = 0;
    while (sclLine !== 1'b1 && n < 9000) begin
      @(posedge core_clk);
      n++;
    end
    if (sclLine !== 1'b1) stalled = 1'b1;
    hw();
    s = sdaLine;
    sclPull <= 1'b1;
    // Let the unit react to the falling clock before the data line moves.
    hw();
  endtask
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) bit1(d[i], q[i]);
    bit1(a, r);
  endtask
  task automatic start();
    hw();
    sdaPull <= 1'b0;
    sclPull <= 1'b0;
    hw();
    sdaPull <= 1'b1;
    hw();
    sclPull <= 1'b1;
  endtask
  task automatic stop();
    sdaPull <= 1'b1;
    hw();
    sclPull <= 1'b0;
    hw();
    sdaPull <= 1'b0;
    hw();
  endtask
  // Sets the data line while the clock is low, so no START or STOP appears.
  task automatic hold(input logic b);
    sclPull <= 1'b1;
    hw();
    sdaPull <= b;
    hw();
    sclPull <= 1'b0;
    hw();
  endtask
endmodule

// ==== test/two_wire_unit_tb.sv ====
// Self-checking bench for the two-wire status and recovery unit.
`timescale 1ns/10ps
module two_wire_unit_tb import two_wire_pkg::*;;
  localparam logic [7:0] AK = 8'h01 << ACK_BIT;
  localparam logic [7:0] SB = 8'h01 << START_BIT;
  localparam logic [7:0] PB = 8'h01 << STOP_BIT;
  localparam logic [7:0] IB = 8'h01 << INT_BIT;
  logic              core_clk = 1'b0, rst = 1'b1;
  logic              awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic              bready = 1'b1, rready = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, v, rdata;
  logic [3:0]        wstrb = 4'hF;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              sclOut, sclOe, sdaOut, sdaOe, sclPull, sdaPull, r, pe;
  logic [1:0]        bresp, rresp, rr;
  logic [7:0]        q;
  wire               sclIn = !(sclOe === 1'b1 || sclPull);
  wire               sdaIn = !(sdaOe === 1'b1 || sdaPull);
  wire [3:0]         hs = {rvalid, arready, bvalid, awready};
  int                n, mismatches = 0, compares = 0;
  always #2 core_clk = ~core_clk;
  two_wire_unit u_dut (
    .core_clk (core_clk),
    .rst      (rst),
    .awaddr   (awaddr),
    .awvalid  (awvalid),
    .awready  (awready),
    .wdata    (wdata),
    .wstrb    (wstrb),
    .wvalid   (wvalid),
    .wready   (wready),
    .bresp    (bresp),
    .bvalid   (bvalid),
    .bready   (bready),
    .araddr   (araddr),
    .arvalid  (arvalid),
    .arready  (arready),
    .rdata    (rdata),
    .rresp    (rresp),
    .rvalid   (rvalid),
    .rready   (rready),
    .sclIn    (sclIn),
    .sclOut   (sclOut),
    .sclOe    (sclOe),
    .sdaIn    (sdaIn),
    .sdaOut   (sdaOut),
    .sdaOe    (sdaOe)
  );
  bus_peer u_peer (.core_clk, .sclLine(sclIn), .sdaLine(sdaIn), .sclPull, .sdaPull);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wt(input int k);
    int t;
    t = 0;
    do begin
      @(posedge core_clk);
      t++;
    end while (hs[k] !== 1'b1 && t < 9000);
    if (hs[k] !== 1'b1) begin
      mismatches++;
      close_out();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    wt(0);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wt(1);
    rr = bresp;
  endtask
  task automatic rd(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    wt(2);
    arvalid <= 1'b0;
    wt(3);
    v = rdata;
    rr = rresp;
  endtask
  task automatic rc(input string nm, input logic [4:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, e, v);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rc("status idle", STAT_OFF, 32'hF8);
    rc("control", CTRL_OFF, 32'h0);
    wr(STAT_OFF, 8'h00);
    chk("bresp", RESP_OKAY, rr);
    wr(5'h10, 8'hFF);
    chk("bresp unmapped", RESP_SLVERR, rr);
    rc("status ro", STAT_OFF, 32'hF8);
    rc("unmapped", 5'h10, 32'h0);
    chk("rresp", RESP_SLVERR, rr);
    wr(OWN_OFF, 8'h54);
    u_peer.start();
    u_peer.xbyte(8'h55, 1'b1, q, r);
    chk("no ack", 1, r);
    rc("ignored", STAT_OFF, 32'hF8);
    u_peer.stop();
    wr(CTRL_OFF, AK);
    u_peer.start();
    u_peer.xbyte(8'h55, 1'b1, q, r);
    chk("ack", 0, r);
    rc("status read", STAT_OFF, ST_SLV_R);
    rc("flag", CTRL_OFF, AK | IB);
    wr(CTRL_OFF, IB);
    wr(DATA_OFF, 8'h5A);
    wr(CTRL_OFF, 8'h00);
    u_peer.xbyte(8'hFF, 1'b0, q, r);
    chk("tx byte", 8'h5A, q);
    rc("last", STAT_OFF, ST_TX_LAST);
    wr(CTRL_OFF, 8'h00);
    u_peer.xbyte(8'hFF, 1'b1, q, r);
    chk("ones", 8'hFF, q);
    rc("after", STAT_OFF, 32'hF8);
    u_peer.stop();
    wr(CTRL_OFF, AK);
    u_peer.start();
    u_peer.xbyte(8'h55, 1'b1, q, r);
    wr(DATA_OFF, 8'hFF);
    wr(CTRL_OFF, AK);
    repeat (3) u_peer.bit1(1'b1, r);
    u_peer.start();
    rc("bus error", STAT_OFF, ST_BUS_ERR);
    chk("lines free", 0, {sclOe, sdaOe});
    u_peer.stop();
    wr(CTRL_OFF, AK | PB);
    rc("stop cleared", CTRL_OFF, AK);
    rc("recovered", STAT_OFF, 32'hF8);
    u_peer.hold(1'b1);
    wr(CTRL_OFF, AK | SB);
    n = 0;
    pe = 1'b0;
    repeat (12000) begin
      @(posedge core_clk);
      if (sclOe && !pe) n++;
      pe = sclOe;
    end
    chk("pulses", 1, n >= 2);
    u_peer.hold(1'b0);
    n = 0;
    do begin
      rd(STAT_OFF);
      n++;
    end while (v !== 32'h08 && n < 3000);
    chk("start", ST_START, v);
    chk("bus stall", 0, u_peer.stalled);
    close_out();
  end
endmodule
